/* src/spi_port_with_fifo.sv */
// Serial port engine with register file, prescaler and framing
module spi_port_with_fifo
  import spi_port_pkg::*;
(
  // Clock, reset and global controls
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        idle_mode_in,
  // Register port
  input  wire logic [1:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  // Serial pins
  input  wire logic        serial_in_pin_in,
  input  wire logic        shift_clock_pin_in,
  output logic             shift_clock_pin_out,
  output logic             shift_clock_oe_out,
  output logic             serial_out_pin_out,
  output logic             serial_out_oe_out,
  input  wire logic        select_pin_in,
  output logic             select_pin_out,
  output logic             select_pin_oe_out,
  // Module interrupt pulse
  output logic             port_irq_out
);

  // All module state in one record
  typedef struct packed {
    logic [15:0]  rdata;    // Read data, one cycle after strobe
    logic         en;       // Module enable
    logic         sidl;     // Halt in idle
    logic         ov;       // Receive overflow flag
    logic [2:0]   isel;     // Interrupt condition select
    logic [15:0]  con1;     // First control register
    logic [15:0]  con2;     // Second control register
    logic [15:0]  txhold;   // Standard transmit holding word
    logic [15:0]  rxhold;   // Standard receive holding word
    logic         tbf;      // Standard transmit full
    logic         rbf;      // Standard receive full
    shift_state_e st;       // Shift engine state
    logic [4:0]   ecnt;     // Clock edge index in the word
    logic [8:0]   div;      // Prescaler countdown
    logic         act;      // Master clock at active level
    logic [15:0]  txsh;     // Outgoing shift register
    logic [15:0]  rxsh;     // Incoming shift register
    logic [2:0]   sdi_s;    // Data input synchroniser
    logic [2:0]   sck_s;    // Clock input synchroniser
    logic [2:0]   ss_s;     // Select input synchroniser
    logic         sck_st;   // Settled clock pin level
    logic         ss_st;    // Settled select pin level
    logic         sck_o;    // Clock pin drive
    logic         sck_oe;   // Clock pin enable
    logic         sdo_o;    // Data pin drive
    logic         sdo_oe;   // Data pin enable
    logic         ss_o;     // Select pin drive
    logic         ss_oe;    // Select pin enable
    logic         irq;      // Interrupt pulse
  } port_s;

  port_s q;  // Registered state
  port_s d;  // Next state

  // Queue hookup
  logic        tx_push, tx_pop, rx_push, rx_pop;
  logic [15:0] tx_dout, rx_dout, rxw;
  logic [3:0]  tx_cnt, rx_cnt;
  logic        tx_full, tx_empty, rx_full, rx_empty;

  // Decoded configuration and per-cycle events
  logic       mst, w16, cke, cpol, sel_use, frm, fsd, fpol, fe, qen;
  logic       run, tick, ev, lead, chg, take, done, ov_set, ov_clr;
  logic       tx_avail, fpulse, sel_ok, pulse, sh_empty;
  logic [4:0] last_e;
  logic [8:0] reload;

  // Divider ratio minus one from both prescale fields
  function automatic logic [8:0] ratio_m1(input logic [1:0] pri,
                                          input logic [2:0] sec);
    logic [6:0] p;
    logic [3:0] s;
    p = 7'h01;
    s = 4'h8 - 4'(sec);                 // 111 is 1, 000 is 8
    case (pri)
      2'b11:   p = 7'h01;
      2'b10:   p = 7'h04;
      2'b01:   p = 7'h10;
      default: p = 7'h40;
    endcase
    ratio_m1 = 9'(11'(p) * 11'(s) - 11'h001);
  endfunction : ratio_m1

  // Transmit queue, fed by buffer writes
  word_queue u_tx_q (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .flush_in  (!q.en),
    .push_in   (tx_push),
    .data_in   (wdata_in),
    .pop_in    (tx_pop),
    .data_out  (tx_dout),
    .count_out (tx_cnt),
    .full_out  (tx_full),
    .empty_out (tx_empty)
  );

  // Receive queue, drained by buffer reads
  word_queue u_rx_q (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .flush_in  (!q.en),
    .push_in   (rx_push),
    .data_in   (rxw),
    .pop_in    (rx_pop),
    .data_out  (rx_dout),
    .count_out (rx_cnt),
    .full_out  (rx_full),
    .empty_out (rx_empty)
  );

  // Next-state logic for registers, shift engine and pins
  always_comb begin
    d       = q;
    tx_push = 1'b0;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    rx_pop  = 1'b0;
    take    = 1'b0;
    done    = 1'b0;
    ov_set  = 1'b0;
    ov_clr  = 1'b0;
    tick    = 1'b0;
    ev      = 1'b0;
    // Configuration fields
    mst  = q.con1[MST_BIT];
    w16  = q.con1[WIDTH_BIT];
    cke  = q.con1[EDGE_BIT];
    cpol = q.con1[CPOL_BIT];
    sel_use = q.con1[SELUSE_BIT];
    frm  = q.con2[FRM_BIT];
    fsd  = q.con2[FSD_BIT];
    fpol = q.con2[FPOL_BIT];
    fe   = q.con2[FE_BIT];
    qen  = q.con2[QEN_BIT];
    run  = q.en && !(q.sidl && idle_mode_in);
    last_e = w16 ? LAST_E16 : LAST_E8;
    reload = ratio_m1(q.con1[PRI_LSB +: 2], q.con1[SEC_LSB +: 3]);
    tx_avail = qen ? !tx_empty : q.tbf;
    // Pins pass three flops; a clock or select level counts once the last two agree
    d.sdi_s = {q.sdi_s[1:0], serial_in_pin_in};
    d.sck_s = {q.sck_s[1:0], shift_clock_pin_in};
    d.ss_s  = {q.ss_s[1:0], select_pin_in};
    if (q.sck_s[1] == q.sck_s[2]) begin
      d.sck_st = q.sck_s[2];
    end
    if (q.ss_s[1] == q.ss_s[2]) begin
      d.ss_st = q.ss_s[2];
    end
    fpulse = (q.ss_st == fpol);
    sel_ok = !(sel_use && !frm && q.ss_st);
    // Edge events: prescaler in master role, pin in slave role
    if (mst) begin
      if (q.st != ST_IDLE) begin
        if (q.div == 9'h000) begin
          tick  = 1'b1;
          d.div = reload;
        end else begin
          d.div = q.div - 9'h001;
        end
      end
      ev   = tick && (q.st == ST_SHIFT);
      lead = !q.act;
    end else begin
      ev = (q.sck_s[1] == q.sck_s[2]) && (q.sck_s[2] != q.sck_st)
           && (q.st == ST_SHIFT) && sel_ok;
      lead = q.sck_s[2] ^ cpol;
    end
    // Edge bit picks which edge changes data; the other samples
    chg = cke ? !lead : lead;
    // Shift engine, frozen when halted
    if (run) begin
      if (ev) begin
        d.act = !q.act;
        if (!chg) begin
          d.rxsh = {q.rxsh[14:0], q.sdi_s[2]};
        end else if (q.ecnt != 5'h00) begin
          d.txsh = {q.txsh[14:0], 1'b0};
        end
        if (q.ecnt == last_e) begin
          done = 1'b1;
        end else begin
          d.ecnt = q.ecnt + 5'h01;
        end
      end
      case (q.st)
        ST_IDLE: begin
          // Master waits for data and, when the frame pin is an input, for an incoming frame pulse
          if (mst && tx_avail && (!(frm && fsd) || fpulse)) begin
            take = 1'b1;
            d.st = (frm && !fsd && !fe) ? ST_PRE : ST_SHIFT;
          end else if (!mst && (!(frm && fsd) || fpulse)) begin
            take = tx_avail;
            d.st = ST_SHIFT;
          end
        end
        ST_PRE: begin
          // Frame pulse stands one half clock period ahead
          if (tick) begin
            d.st = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (done) begin
            d.st   = ST_IDLE;
            d.ecnt = 5'h00;
            d.act  = 1'b0;
          end else if (!mst && !sel_ok) begin
            d.ecnt = 5'h00;
          end
        end
        default: d.st = ST_IDLE;
      endcase
    end
    // Loading the shifter frees the holding word or queue slot
    if (take) begin
      d.txsh = qen ? tx_dout : q.txhold;
      d.ecnt = 5'h00;
      d.act  = 1'b0;
      d.div  = reload;
      tx_pop = qen;
      if (!qen) begin
        d.tbf = 1'b0;
      end
    end else if (run && (q.st == ST_IDLE) && !mst) begin
      d.txsh = 16'h0000;
    end
    // A finished word goes to the holding word or receive queue
    rxw = w16 ? d.rxsh : {8'h00, d.rxsh[7:0]};
    if (done) begin
      if (qen) begin
        if (rx_full) begin
          ov_set = 1'b1;
        end else begin
          rx_push = 1'b1;
        end
      end else if (q.rbf) begin
        ov_set = 1'b1;
      end else begin
        d.rxhold = rxw;
        d.rbf    = 1'b1;
      end
    end
    // Module disabled: engine parked
    if (!q.en) begin
      d.st   = ST_IDLE;
      d.ecnt = 5'h00;
      d.act  = 1'b0;
    end
    // Register writes
    if (wr_in) begin
      if (addr_in == STAT_IDX) begin
        d.en    = wdata_in[EN_BIT];
        d.sidl  = wdata_in[SIDL_BIT];
        d.isel  = wdata_in[ISEL_LSB +: 3];
        ov_clr  = !wdata_in[ROV_BIT];
      end else if (addr_in == CON1_IDX) begin
        d.con1 = wdata_in & CON1_MASK;
      end else if (addr_in == CON2_IDX) begin
        d.con2 = wdata_in & CON2_MASK;
      end else if (addr_in == BUF_IDX) begin
        if (qen) begin
          tx_push = !tx_full;
        end else begin
          d.txhold = wdata_in;
          d.tbf    = 1'b1;
        end
      end
    end
    // Overflow: a new overflow wins over a clearing write
    d.ov = (q.ov && !ov_clr) || ov_set;
    // Register reads; data stand one cycle only
    // Empty flags are only meaningful in queue mode; they read 0 otherwise
    sh_empty = (q.st == ST_IDLE) || (!mst && q.ecnt == 5'h00);
    d.rdata = 16'h0000;
    if (rd_in) begin
      if (addr_in == STAT_IDX) begin
        d.rdata[EN_BIT]           = q.en;
        d.rdata[SIDL_BIT]         = q.sidl;
        d.rdata[BEC_LSB +: 3]     = mst ? tx_cnt[2:0] : rx_cnt[2:0];
        d.rdata[SHEMP_BIT]        = qen && sh_empty;
        d.rdata[ROV_BIT]          = q.ov;
        d.rdata[RXMPT_BIT]        = qen && rx_empty;
        d.rdata[ISEL_LSB +: 3]    = q.isel;
        d.rdata[TBF_BIT]          = qen ? tx_full : q.tbf;
        d.rdata[RBF_BIT]          = qen ? rx_full : q.rbf;
      end else if (addr_in == CON1_IDX) begin
        d.rdata = q.con1;
      end else if (addr_in == CON2_IDX) begin
        d.rdata = q.con2;
      end else if (addr_in == BUF_IDX) begin
        if (qen) begin
          d.rdata = rx_dout;
          rx_pop  = !rx_empty;
        end else begin
          d.rdata = q.rxhold;
          // A word stored this same cycle keeps the flag set
          d.rbf   = done && !q.rbf;
        end
      end
    end
    // Interrupt pulse per selected condition in queue mode, per stored word otherwise
    d.irq = 1'b0;
    if (qen) begin
      case (q.isel)
        IS_TX_FULL:  d.irq = tx_push && (tx_cnt == 4'h7);
        IS_TX_EMPTY: d.irq = take && (tx_cnt == 4'h1);
        IS_TX_DONE:  d.irq = done;
        IS_TX_SLOT:  d.irq = take;
        IS_RX_FULL:  d.irq = rx_push && (rx_cnt == 4'h7);
        IS_RX_3Q:    d.irq = rx_push && (rx_cnt == 4'h5);
        IS_RX_AVAIL: d.irq = rx_push;
        default:     d.irq = rx_pop && (rx_cnt == 4'h1);
      endcase
    end else begin
      d.irq = done && !q.rbf;
    end
    // Pins go to the module only while it is enabled
    pulse = (d.st == ST_PRE) || ((d.st == ST_SHIFT) &&
            (mst ? (fe && d.ecnt < 5'h02) : d.ecnt == 5'h00));
    d.sck_o  = d.act ^ cpol;
    d.sck_oe = q.en && mst && !q.con1[CLK_OFF_BIT];
    d.sdo_o  = w16 ? d.txsh[15] : d.txsh[7];
    d.sdo_oe = q.en && !q.con1[SDO_OFF_BIT];
    d.ss_o   = pulse ? fpol : !fpol;
    d.ss_oe  = q.en && frm && !fsd;
  end

  // State register; every reset value is zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign rdata_out           = q.rdata;
  assign shift_clock_pin_out = q.sck_o;
  assign shift_clock_oe_out  = q.sck_oe;
  assign serial_out_pin_out  = q.sdo_o;
  assign serial_out_oe_out   = q.sdo_oe;
  assign select_pin_out      = q.ss_o;
  assign select_pin_oe_out   = q.ss_oe;
  assign port_irq_out        = q.irq;

endmodule : spi_port_with_fifo

/* shared/spi_port_pkg.sv */
// Constants, register layout and state codes of the serial port
// Functional notes
// - Single buffer or eight-deep queues, selectable
// - Four pins; three- and two-pin arrangements
// - Framed protocol, master or slave, four variants
// - Master starts shifting when buffer written
// - Enable bit 15 activates module and pins
// - Halt-in-idle bit 13 stops module in idle
// - Element count: pending (master), unread (slave)
// - Shifter-empty bit 7 shows idle shift register in queue mode
// - Overflow bit 6 drops word, software clears
// - Receive-queue-empty bit 5 in queue mode
// - Transmit interrupt select codes 111 to 100
// - Receive interrupt select codes 011 to 000
// - Standard transmit-full set on write, cleared on load
// - Queue transmit-full tracks last free slot
// - Standard receive-full set on store, cleared on read
// - Queue receive-full tracks last unread slot
// - Master clock from primary and secondary dividers
// - Width bit selects 16 or 8 bits
// - Polarity sets idle level; edge bit picks change
// - Frame pulse direction, polarity and timing bits
// - Divider field encodings as documented
package spi_port_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] STAT_IDX = 2'h0;
  localparam logic [1:0] CON1_IDX = 2'h1;
  localparam logic [1:0] CON2_IDX = 2'h2;
  localparam logic [1:0] BUF_IDX  = 2'h3;

  // Status and control register fields
  localparam int EN_BIT    = 15;
  localparam int SIDL_BIT  = 13;
  localparam int BEC_LSB   = 8;
  localparam int SHEMP_BIT = 7;
  localparam int ROV_BIT   = 6;
  localparam int RXMPT_BIT = 5;
  localparam int ISEL_LSB  = 2;
  localparam int TBF_BIT   = 1;
  localparam int RBF_BIT   = 0;

  // First control register fields
  localparam int CLK_OFF_BIT = 12;
  localparam int SDO_OFF_BIT = 11;
  localparam int WIDTH_BIT   = 10;
  localparam int PHASE_BIT   = 9;
  localparam int EDGE_BIT    = 8;
  localparam int SELUSE_BIT  = 7;
  localparam int CPOL_BIT    = 6;
  localparam int MST_BIT     = 5;
  localparam int SEC_LSB     = 2;
  localparam int PRI_LSB     = 0;
  localparam logic [15:0] CON1_MASK = 16'h1fff;

  // Second control register fields
  localparam int FRM_BIT  = 15;
  localparam int FSD_BIT  = 14;
  localparam int FPOL_BIT = 13;
  localparam int FE_BIT   = 1;
  localparam int QEN_BIT  = 0;
  localparam logic [15:0] CON2_MASK = 16'he003;

  // Reset values of the status and both control registers
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] CON1_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h0000;

  // Queue geometry
  localparam int QDEPTH = 8;
  localparam int QW     = 16;

  // Last edge index of a word, 8 and 16 bit
  localparam logic [4:0] LAST_E8  = 5'h0f;
  localparam logic [4:0] LAST_E16 = 5'h1f;

  // Interrupt condition select codes
  localparam logic [2:0] IS_TX_FULL  = 3'h7;
  localparam logic [2:0] IS_TX_EMPTY = 3'h6;
  localparam logic [2:0] IS_TX_DONE  = 3'h5;
  localparam logic [2:0] IS_TX_SLOT  = 3'h4;
  localparam logic [2:0] IS_RX_FULL  = 3'h3;
  localparam logic [2:0] IS_RX_3Q    = 3'h2;
  localparam logic [2:0] IS_RX_AVAIL = 3'h1;
  localparam logic [2:0] IS_RX_EMPTY = 3'h0;

  // Shift engine states, Gray along idle-pre-shift
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PRE   = 2'b01,
    ST_SHIFT = 2'b11
  } shift_state_e;

endpackage : spi_port_pkg

/* src/word_queue.sv */
// Eight-deep word queue used for transmit and receive paths
module word_queue
  import spi_port_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          ce_in,
  input  wire logic          flush_in,
  // Write side
  input  wire logic          push_in,
  input  wire logic [QW-1:0] data_in,
  // Read side
  input  wire logic          pop_in,
  output logic      [QW-1:0] data_out,
  // Occupancy
  output logic      [3:0]    count_out,
  output logic               full_out,
  output logic               empty_out
);

  // Whole queue state in one record
  typedef struct packed {
    logic [QDEPTH-1:0][QW-1:0] mem;  // Storage words
    logic [2:0]                wp;   // Write pointer
    logic [2:0]                rp;   // Read pointer
    logic [3:0]                cnt;  // Words held
  } queue_s;

  queue_s q;  // Registered state
  queue_s d;  // Next state

  logic do_push;  // Accepted write
  logic do_pop;   // Accepted read

  // Pointer and count update; a push into a full queue is dropped
  always_comb begin
    d       = q;
    do_push = push_in && (q.cnt != 4'(QDEPTH));
    do_pop  = pop_in && (q.cnt != 4'h0);
    if (do_push) begin
      d.mem[q.wp] = data_in;
      d.wp        = q.wp + 3'h1;
    end
    if (do_pop) begin
      d.rp = q.rp + 3'h1;
    end
    // Count follows both sides so simultaneous access nets out
    d.cnt = q.cnt + 4'(do_push) - 4'(do_pop);
    if (flush_in) begin
      d.wp  = 3'h0;
      d.rp  = 3'h0;
      d.cnt = 4'h0;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // Head word and flags come straight from the state
  assign data_out  = q.mem[q.rp];
  assign count_out = q.cnt;
  assign full_out  = (q.cnt == 4'(QDEPTH));
  assign empty_out = (q.cnt == 4'h0);

endmodule : word_queue

/* verif/spi_port_properties.sv */
// Port-level timing checks for the serial port with queues
module spi_port_properties
  import spi_port_pkg::*;
(
  // Clock, reset and global controls
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        idle_mode_in,
  // Register port writes
  input wire logic [1:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  // Design outputs under watch
  input wire logic        shift_clock_pin_out,
  input wire logic        shift_clock_oe_out,
  input wire logic        serial_out_oe_out,
  input wire logic        select_pin_oe_out,
  input wire logic        port_irq_out
);
  logic        en_q;    // Shadow of the module enable bit
  logic        halt_q;  // Shadow of the halt-in-idle bit
  logic [15:0] con1_q;  // Shadow of control one
  logic [15:0] con2_q;  // Shadow of control two
  logic        last_q;  // Clock pin one cycle back
  logic [9:0]  gap_q;   // Cycles since the clock pin last moved
  logic [9:0]  ratio;   // Cycles per clock half period
  logic        tog;     // Clock pin moved this cycle
  logic        hd;      // Engine must stand frozen

  // Ratio from both divider fields; code 11 and 111 mean divide by one
  always_comb begin
    ratio = (10'h1 << {2'h3 - con1_q[1:0], 1'b0}) * (10'h8 - con1_q[4:2]);
    tog   = shift_clock_pin_out != last_q;
    hd    = halt_q && idle_mode_in;
  end

  // Shadows follow register writes; gap saturates so it never wraps
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_q   <= 1'b0;
      halt_q <= 1'b0;
      con1_q <= 16'h0000;
      con2_q <= 16'h0000;
      last_q <= 1'b0;
      gap_q  <= 10'h3ff;
    end else begin
      last_q <= shift_clock_pin_out;
      gap_q  <= tog ? 10'h1 : (gap_q == 10'h3ff ? gap_q : gap_q + 10'h1);
      if (wr_in && ce_in && addr_in == STAT_IDX) begin
        en_q   <= wdata_in[EN_BIT];
        halt_q <= wdata_in[SIDL_BIT];
      end
      if (wr_in && ce_in && addr_in == CON1_IDX) begin
        con1_q <= wdata_in;
      end
      if (wr_in && ce_in && addr_in == CON2_IDX) begin
        con2_q <= wdata_in;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_irq_single_pulse: assert property (
    port_irq_out |=> !port_irq_out) else $error("irq pulse too long");
  chk_clock_pin_owner: assert property (
    shift_clock_oe_out == $past(en_q && con1_q[MST_BIT]
      && !con1_q[CLK_OFF_BIT])) else $error("clock enable wrong");
  chk_data_pin_owner: assert property (
    serial_out_oe_out == $past(en_q && !con1_q[SDO_OFF_BIT]))
    else $error("data enable wrong");
  chk_frame_pin_owner: assert property (
    select_pin_oe_out == $past(en_q && con2_q[FRM_BIT] && !con2_q[FSD_BIT]))
    else $error("frame enable wrong");
  chk_clock_spacing: assert property (
    tog && shift_clock_oe_out && $past(shift_clock_oe_out) |-> gap_q >= ratio)
    else $error("clock edges too close");
  chk_halt_freeze: assert property (
    hd && $past(hd) && $past(hd, 2) |-> $stable(shift_clock_pin_out))
    else $error("clock moved while halted");
  chk_tx_start: assert property (
    wr_in && ce_in && addr_in == BUF_IDX && en_q && con1_q[MST_BIT]
      && !con2_q[QEN_BIT] && !hd |-> ##[1:600] tog)
    else $error("transfer did not start");
  chk_idle_level: assert property (
    $rose(shift_clock_oe_out) |-> shift_clock_pin_out == con1_q[CPOL_BIT])
    else $error("idle clock level wrong");
endmodule : spi_port_properties

/* verif/spi_loop_partner.sv */
// Far side: a slow loopback peripheral on the serial pins
module spi_loop_partner #(
  parameter int DLY = 2  // Cycles of answer delay
) (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  input  wire logic sck_in,
  input  wire logic sck_oe_in,
  output logic      sdi_out,
  output logic      sck_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DLY-1:0] dl_q = '0;  // Echo delay line
  logic           sck_q = 1'b0;  // Last driven clock level

  // Released data line toggles every cycle so no stale bit reads back
  always_ff @(posedge clk_in) begin
    dl_q <= {dl_q[DLY-2:0], sdo_oe_in ? sdo_in : ~dl_q[0]};
    if (sck_oe_in) begin
      sck_q <= sck_in;
    end
  end

  // Clock echo stands still when the port lets it go
  assign sdi_out = dl_q[DLY-1];
  assign sck_out = sck_oe_in ? sck_in : sck_q;
endmodule : spi_loop_partner

/* verif/spi_port_with_fifo_bench.sv */
// Self-checking bench of the serial port in master loopback
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
  end
module spi_port_with_fifo_bench
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_in, ce_in, idle_mode_in;
  logic [1:0]  addr_in;
  logic [15:0] wdata_in, rdata_out;
  logic        wr_in, rd_in, port_irq_out;
  logic        sdi, sck_i, shift_clock_pin_out, shift_clock_oe_out;
  logic        serial_out_pin_out, serial_out_oe_out;
  logic        select_pin_out, select_pin_oe_out;
  int          err_total = 0;
  int          n_compared = 0;
  typedef struct packed { logic [15:0] c1, d, e; } row_s;
  // Control one, word sent, word expected back
  row_s rows [4] = '{'{16'h043d, 16'ha5c3, 16'ha5c3},
                     '{16'h003d, 16'h1234, 16'h0034},
                     '{16'h047d, 16'h8001, 16'h8001},
                     '{16'h057d, 16'h7f0e, 16'h7f0e}};
  logic [15:0] rst_v [3] = '{STAT_RST, CON1_RST, CON2_RST};

  spi_port_with_fifo i_spi_port_with_fifo (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .idle_mode_in(idle_mode_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .serial_in_pin_in(sdi), .shift_clock_pin_in(sck_i),
    .shift_clock_pin_out(shift_clock_pin_out),
    .shift_clock_oe_out(shift_clock_oe_out),
    .serial_out_pin_out(serial_out_pin_out),
    .serial_out_oe_out(serial_out_oe_out), .select_pin_in(1'b1),
    .select_pin_out(select_pin_out), .select_pin_oe_out(select_pin_oe_out),
    .port_irq_out(port_irq_out));
  spi_loop_partner i_spi_loop_partner (
    .clk_in(clk_in), .sdo_in(serial_out_pin_out),
    .sdo_oe_in(serial_out_oe_out), .sck_in(shift_clock_pin_out),
    .sck_oe_in(shift_clock_oe_out), .sdi_out(sdi), .sck_out(sck_i));

  // Free-running 125 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    // Sampled at the edge that ends the data cycle, before it updates
    @(posedge clk_in);
    d = rdata_out;
  endtask : reg_rd

  task automatic st_chk(input string nm, input logic [15:0] m, e);
    logic [15:0] v;
    reg_rd(STAT_IDX, v);
    `CHK(nm, e, v & m)
  endtask : st_chk

  task automatic buf_chk(input logic [15:0] e);
    logic [15:0] v;
    reg_rd(BUF_IDX, v);
    `CHK("rx word", e, v)
  endtask : buf_chk

  // Bounded wait for the one-cycle interrupt pulse
  task automatic wait_irq;
    int n;
    n = 0;
    while (port_irq_out !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK("irq", 1'b1, port_irq_out)
  endtask : wait_irq

  // Module off first, so role and queue mode are set while idle
  task automatic setup(input logic [15:0] c1, c2);
    reg_wr(STAT_IDX, 16'h0000);
    reg_wr(CON1_IDX, c1);
    reg_wr(CON2_IDX, c2);
    reg_wr(STAT_IDX, 16'h8000);
  endtask : setup

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    give_verdict();
  end

  initial begin
    logic [15:0] v;
    rst_in = 1'b1;
    ce_in = 1'b1;
    idle_mode_in = 1'b0;
    addr_in = 2'h0;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      reg_rd(2'(i), v);
      `CHK("reset value", rst_v[i], v)
    end
    // Clock enable low: a register write must leave no trace
    ce_in <= 1'b0;
    reg_wr(CON1_IDX, 16'h0123);
    ce_in <= 1'b1;
    reg_rd(CON1_IDX, v);
    `CHK("frozen write", CON1_RST, v)
    // Standard mode words through the loopback
    foreach (rows[i]) begin
      setup(rows[i].c1, 16'h0000);
      reg_wr(BUF_IDX, rows[i].d);
      wait_irq();
      st_chk("full flags", 16'h0003, 16'h0001);
      buf_chk(rows[i].e);
      st_chk("rx full", 16'h0001, 16'h0000);
    end
    // Second word arrives unread: dropped, flag until software clears
    setup(16'h043d, 16'h0000);
    reg_wr(BUF_IDX, 16'h3c3c);
    wait_irq();
    reg_wr(BUF_IDX, 16'hc3c3);
    repeat (700) @(posedge clk_in);
    st_chk("overflow", 16'h0041, 16'h0041);
    buf_chk(16'h3c3c);
    reg_wr(STAT_IDX, 16'h8000);
    st_chk("overflow clear", 16'h0040, 16'h0000);
    // Halted in idle: nothing completes until idle ends
    setup(16'h043d, 16'h0000);
    reg_wr(STAT_IDX, 16'ha000);
    idle_mode_in <= 1'b1;
    reg_wr(BUF_IDX, 16'h5aa5);
    repeat (300) @(posedge clk_in);
    st_chk("halted", 16'h0001, 16'h0000);
    idle_mode_in <= 1'b0;
    wait_irq();
    buf_chk(16'h5aa5);
    // Queue mode: nine words, eight fit, the ninth overflows
    setup(16'h043d, 16'h0001);
    for (int i = 0; i < 9; i++) reg_wr(BUF_IDX, 16'h1100 + 16'(i));
    st_chk("tx queue full", 16'h0702, 16'h0002);
    repeat (9 * 560) @(posedge clk_in);
    st_chk("queue done", 16'h07e3, 16'h00c1);
    for (int i = 0; i < 8; i++) buf_chk(16'h1100 + 16'(i));
    st_chk("rx queue empty", 16'h0021, 16'h0020);
    give_verdict();
  end
endmodule : spi_port_with_fifo_bench

bind spi_port_with_fifo spi_port_properties i_spi_port_properties (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .idle_mode_in(idle_mode_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .shift_clock_pin_out(shift_clock_pin_out),
  .shift_clock_oe_out(shift_clock_oe_out),
  .serial_out_oe_out(serial_out_oe_out),
  .select_pin_oe_out(select_pin_oe_out), .port_irq_out(port_irq_out));
